// ### bench/dsg_top_assertions.sv
// checker: port-level properties of the deep-sleep clock gating block
`timescale 1ns/1ps
module dsg_checker
    import dsg_pkg::*;
#(
    parameter logic [1:0] MAX_RATE = RATE_500K
)
(
    input wire logic              core_clk,
    input wire logic              rst_n,
    input wire logic              converter_access,
    input wire logic              watchdog_access,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic [DATA_W-1:0] s_axi_rdata,
    input wire logic [1:0]        s_axi_rresp,
    input wire logic              s_axi_rvalid,
    input wire logic              converter_clk_en,
    input wire logic              watchdog_clk_en,
    input wire logic [1:0]        converter_rate,
    input wire logic              converter_fault,
    input wire logic              watchdog_fault
);
    // bit 6 may still read one before the first write, so it is left out of the mask
    localparam logic [31:0] RSVD_MASK = 32'hFFFE_FCB7;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    conv_gated_fault_a: assert property (
        converter_access && !converter_clk_en |=> converter_fault)
        else $error("converter access while gated gave no fault");
    wdog_gated_fault_a: assert property (
        watchdog_access && !watchdog_clk_en |=> watchdog_fault)
        else $error("watchdog access while gated gave no fault");
    conv_live_quiet_a: assert property (
        converter_access && converter_clk_en |=> !converter_fault)
        else $error("clocked converter answered with a fault");
    wdog_live_quiet_a: assert property (
        watchdog_access && watchdog_clk_en |=> !watchdog_fault)
        else $error("clocked watchdog answered with a fault");
    fault_cause_a: assert property (
        converter_fault |-> $past(converter_access) && !$past(converter_clk_en))
        else $error("converter fault without a gated access");
    rate_clamp_a: assert property (converter_rate <= MAX_RATE)
        else $error("converter rate above the maximum");
    reset_gate_a: assert property (
        !$past(rst_n) |-> !converter_clk_en && !watchdog_clk_en && converter_rate == RATE_125K)
        else $error("units clocked right after reset");
    gate_layout_a: assert property (
        s_axi_arvalid && s_axi_arready && s_axi_araddr == OFS_DEEP_GATE_REG0
        |=> s_axi_rvalid && s_axi_rresp == RESP_OKAY && (s_axi_rdata & RSVD_MASK) == ZERO_WORD)
        else $error("gate register read shows reserved bits");
endmodule : dsg_checker

bind dsg_top dsg_checker #(.MAX_RATE(MAX_RATE)) u_dsg_checker (
    .core_clk(core_clk), .rst_n(rst_n), .converter_access(converter_access),
    .watchdog_access(watchdog_access), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .converter_clk_en(converter_clk_en), .watchdog_clk_en(watchdog_clk_en),
    .converter_rate(converter_rate), .converter_fault(converter_fault),
    .watchdog_fault(watchdog_fault));

// ### bench/dsg_unit_model.sv
// partner: one gated unit issuing bus accesses and judging the fault answer
`timescale 1ns/1ps
module dsg_unit_model (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        poke,
    input  wire logic        clk_en,
    input  wire logic        fault,
    output logic             access,
    output logic [15:0]      miss_cnt
);
    logic fault_due_r;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            access      <= 1'b0;
            fault_due_r <= 1'b0;
            miss_cnt    <= 16'h0000;
        end else begin
            // a unit without clock cannot answer, the fabric must fault instead
            access      <= poke;
            fault_due_r <= access & ~clk_en;
            if (fault !== fault_due_r) begin
                miss_cnt <= miss_cnt + 16'h0001;
            end
        end
    end
endmodule : dsg_unit_model

// ### bench/test_deep_sleep_clock_gating.sv
// testbench: registers, mode gating and gated-access faults of the clock gating block
`timescale 1ns/1ps
module test_deep_sleep_clock_gating;
    import dsg_pkg::*;
    localparam logic [1:0]  TB_MAX = RATE_250K;
    localparam logic [31:0] LIVE   = 32'h0001_0308;
    logic              core_clk = 1'b0;
    logic              rst_n;
    dsg_mode_e         power_mode;
    logic              conv_acc, wdog_acc, poke_c, poke_w, dir_c, dir_w, rand_on;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [31:0]       wdata, rdata;
    logic [31:0]       seed = 32'h6c0a_c5f1;
    logic [3:0]        wstrb;
    logic              awvalid, awready, wvalid, wready, bvalid, bready;
    logic              arvalid, arready, rvalid, rready;
    logic [1:0]        bresp, rresp, conv_rate;
    logic              conv_en, wdog_en, conv_flt, wdog_flt, irq;
    logic [15:0]       conv_miss, wdog_miss;
    logic [33:0]       rq[$];
    logic [1:0]        bq[$];
    int                errors = 0;
    int                tests_run = 0;
    int                cycles = 0;

    always #12.5 core_clk = ~core_clk;

    dsg_top #(.MAX_RATE(TB_MAX)) u_dsg_top (
        .core_clk(core_clk), .rst_n(rst_n), .power_mode(power_mode),
        .converter_access(conv_acc), .watchdog_access(wdog_acc),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .converter_clk_en(conv_en),
        .watchdog_clk_en(wdog_en), .converter_rate(conv_rate),
        .converter_fault(conv_flt), .watchdog_fault(wdog_flt), .irq(irq));
    dsg_unit_model u_conv_unit (.core_clk(core_clk), .rst_n(rst_n), .poke(poke_c),
        .clk_en(conv_en), .fault(conv_flt), .access(conv_acc), .miss_cnt(conv_miss));
    dsg_unit_model u_wdog_unit (.core_clk(core_clk), .rst_n(rst_n), .poke(poke_w),
        .clk_en(wdog_en), .fault(wdog_flt), .access(wdog_acc), .miss_cnt(wdog_miss));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs

    task automatic give_verdict;
        if (errors == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic axi_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] r);
        logic aw_ok;
        logic w_ok;
        bq.push_back(r);
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge core_clk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge core_clk);
            if (awvalid && awready) aw_ok = 1'b1;
            if (wvalid && wready) w_ok = 1'b1;
            if (aw_ok) awvalid <= 1'b0;
            if (w_ok) wvalid <= 1'b0;
        end
        while (!bvalid) @(posedge core_clk);
        bready <= 1'b0;
    endtask : axi_wr

    task automatic axi_rd(input logic [ADDR_W-1:0] a, input logic [33:0] exp);
        rq.push_back(exp);
        @(posedge core_clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(posedge core_clk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge core_clk); while (!rvalid);
        rready <= 1'b0;
    endtask : axi_rd

    // outputs follow a register or mode change one edge later; two edges leave margin
    task automatic gates(input logic c, input logic w, input logic [1:0] r);
        repeat (2) @(posedge core_clk);
        chk({30'h0, conv_en, wdog_en, conv_rate}, {30'h0, c, w, r});
    endtask : gates

    task automatic poke(input logic c, input logic w);
        @(posedge core_clk);
        dir_c <= c;
        dir_w <= w;
        @(posedge core_clk);
        dir_c <= 1'b0;
        dir_w <= 1'b0;
        repeat (5) @(posedge core_clk);
    endtask : poke

    always @(posedge core_clk) begin
        seed   <= xs(seed);
        poke_c <= (rand_on & seed[0]) | dir_c;
        poke_w <= (rand_on & seed[9]) | dir_w;
    end

    ////////////////////////////////////////////////////////////////////////////
    always @(posedge core_clk) begin
        cycles++;
        if (rvalid && rready) chk({rresp, rdata}, rq.pop_front());
        if (bvalid && bready) chk({32'h0, bresp}, {32'h0, bq.pop_front()});
        if (cycles == 20000) begin
            errors++;
            give_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        power_mode = DSG_MODE_RUN;
        {dir_c, dir_w, rand_on} = 3'h0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = '0;
        araddr = '0;
        wdata = ZERO_WORD;
        wstrb = 4'hF;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        gates(1'b0, 1'b0, RATE_125K);
        axi_rd(OFS_DEEP_GATE_REG0, {RESP_OKAY, DEEP_GATE_RESET});
        axi_rd(OFS_RUN_GATE_REG0, {RESP_OKAY, ZERO_WORD});
        axi_wr(OFS_FAULT_ENABLE, 32'h0000_0001, RESP_OKAY);
        poke(1'b1, 1'b0);
        chk({33'h0, irq}, 34'h1);
        axi_rd(OFS_FAULT_STATUS, {RESP_OKAY, 32'h0000_0001});
        poke(1'b0, 1'b1);
        axi_wr(OFS_FAULT_CLEAR, 32'h0000_0001, RESP_OKAY);
        repeat (2) @(posedge core_clk);
        chk({33'h0, irq}, 34'h0);
        axi_rd(OFS_FAULT_STATUS, {RESP_OKAY, 32'h0000_0002});
        axi_wr(OFS_FAULT_CLEAR, 32'h0000_0003, RESP_OKAY);
        axi_wr(OFS_RUN_CLOCK_CONFIG, 32'h0000_0001, RESP_OKAY);
        axi_wr(OFS_DEEP_GATE_REG0, 32'hFFFF_FFFF, RESP_OKAY);
        axi_rd(OFS_DEEP_GATE_REG0, {RESP_OKAY, LIVE});
        gates(1'b0, 1'b0, RATE_125K);
        power_mode <= DSG_MODE_DEEP;
        gates(1'b1, 1'b1, TB_MAX);
        axi_wr(OFS_RUN_CLOCK_CONFIG, ZERO_WORD, RESP_OKAY);
        gates(1'b0, 1'b0, RATE_125K);
        axi_wr(OFS_RUN_CLOCK_CONFIG, 32'h0000_0001, RESP_OKAY);
        axi_wr(OFS_SLEEP_GATE_REG0, 32'h0001_0100, RESP_OKAY);
        power_mode <= DSG_MODE_SLEEP;
        gates(1'b1, 1'b0, RATE_250K);
        axi_wr(OFS_RUN_GATE_REG0, 32'h0000_0008, RESP_OKAY);
        power_mode <= DSG_MODE_RUN;
        gates(1'b0, 1'b1, RATE_125K);
        power_mode <= DSG_MODE_DEEP;
        for (int r = 0; r < 3; r++) begin
            axi_wr(OFS_DEEP_GATE_REG0, {15'h0, 1'b1, 6'h0, r[1:0], 8'h0}, RESP_OKAY);
            gates(1'b1, 1'b0, (r[1:0] > TB_MAX) ? TB_MAX : r[1:0]);
        end
        axi_wr(12'h200, 32'h0000_0001, RESP_SLVERR);
        axi_rd(12'h200, {RESP_SLVERR, ZERO_WORD});
        rand_on <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            wdata <= seed;
            axi_wr(OFS_DEEP_GATE_REG0, seed, RESP_OKAY);
            axi_rd(OFS_DEEP_GATE_REG0, {RESP_OKAY, wdata & LIVE});
        end
        rand_on <= 1'b0;
        // a lane-2-only write must clear bit 16 and leave the other lanes alone
        axi_wr(OFS_DEEP_GATE_REG0, LIVE, RESP_OKAY);
        wstrb <= 4'h4;
        axi_wr(OFS_DEEP_GATE_REG0, ZERO_WORD, RESP_OKAY);
        wstrb <= 4'hF;
        axi_rd(OFS_DEEP_GATE_REG0, {RESP_OKAY, 32'h0000_0308});
        repeat (4) @(posedge core_clk);
        chk({2'h0, conv_miss, wdog_miss}, 34'h0);
        give_verdict();
    end
endmodule : test_deep_sleep_clock_gating

// ### hw/dsg_gate_sel.sv
// module: picks the gate set that applies in the current power mode
`timescale 1ns/1ps
module dsg_gate_sel
    import dsg_pkg::*;
(
    input  dsg_mode_e mode,
    input  wire logic auto_clock_gate_select,
    input  dsg_gate_s run_gate,
    input  dsg_gate_s sleep_gate,
    input  dsg_gate_s deep_gate,
    output dsg_gate_s active_gate
);

    // without automatic gating the run set stays in force in every mode
    always_comb begin
        active_gate = run_gate;
        if (auto_clock_gate_select) begin
            case (mode)
                DSG_MODE_RUN:   active_gate = run_gate;
                DSG_MODE_SLEEP: active_gate = sleep_gate;
                DSG_MODE_DEEP:  active_gate = deep_gate;
                default:        active_gate = run_gate;
            endcase
        end
    end

endmodule : dsg_gate_sel

// ### hw/dsg_pkg.sv
// package: register map, field layout and shared types of the deep-sleep clock gating block
package dsg_pkg;

    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;

    // system control base, kept for software address maps
    localparam logic [31:0] SYSCTL_BASE = 32'h400F_E000;

    // byte offsets inside the system control window
    localparam logic [ADDR_W-1:0] OFS_RUN_CLOCK_CONFIG = 12'h060;
    localparam logic [ADDR_W-1:0] OFS_RUN_GATE_REG0    = 12'h100;
    localparam logic [ADDR_W-1:0] OFS_SLEEP_GATE_REG0  = 12'h110;
    localparam logic [ADDR_W-1:0] OFS_DEEP_GATE_REG0   = 12'h120;
    localparam logic [ADDR_W-1:0] OFS_FAULT_STATUS     = 12'h130;
    localparam logic [ADDR_W-1:0] OFS_FAULT_ENABLE     = 12'h134;
    localparam logic [ADDR_W-1:0] OFS_FAULT_CLEAR      = 12'h138;

    // gate register field positions, then the auto gating select bit of the run clock config register
    localparam int unsigned BIT_WATCHDOG_GATE  = 3;
    localparam int unsigned BIT_RESET_MARK     = 6;
    localparam int unsigned BIT_RATE_LO        = 8;
    localparam int unsigned BIT_RATE_HI        = 9;
    localparam int unsigned BIT_CONVERTER_GATE = 16;
    localparam int unsigned BIT_AUTO_GATE_SEL  = 0;

    // fault status bit positions
    localparam int unsigned BIT_FAULT_CONV = 0;
    localparam int unsigned BIT_FAULT_WDOG = 1;
    localparam int unsigned NUM_FAULTS     = 2;

    localparam logic [31:0] DEEP_GATE_RESET = 32'h0000_0040;
    localparam logic [31:0] ZERO_WORD       = 32'h0000_0000;

    // converter rate codes
    localparam logic [1:0] RATE_125K = 2'h0;
    localparam logic [1:0] RATE_250K = 2'h1;
    localparam logic [1:0] RATE_500K = 2'h2;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        DSG_MODE_RUN   = 2'b00,
        DSG_MODE_SLEEP = 2'b01,
        DSG_MODE_DEEP  = 2'b10
    } dsg_mode_e;

    typedef struct packed {
        logic       converter_gate;
        logic [1:0] converter_rate_select;
        logic       watchdog_gate;
    } dsg_gate_s;

    localparam dsg_gate_s GATE_RESET = '{converter_gate: 1'b0,
                                         converter_rate_select: RATE_125K,
                                         watchdog_gate: 1'b0};

endpackage : dsg_pkg

// ### hw/dsg_top.sv
// module: deep-sleep clock gating registers with an AXI4-Lite slave and gated-access faults
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps

// Functional notes
// - gate bit one clocks unit, zero stops it
// - access to gated unit answers bus fault
// - gate bits reset to zero, units disabled
// - deep gate register reads 0x00000040 after reset
// - run, sleep, deep sets apply per mode
// - sleep, deep sets only with auto gating select
// - bit 16 gates converter module clock
// - bit 3 gates watchdog module clock
// - bits 9:8 select converter sample rate
// - rate never exceeds device maximum rate
// - reserved bits read zero, software preserves
// - deep gate register decodes at 0x120
module dsg_top
    import dsg_pkg::*;
#(
    parameter logic [1:0] MAX_RATE = RATE_500K
)
(
    input  wire logic                core_clk,
    input  wire logic                rst_n,
    // power mode from the system power controller
    input  dsg_mode_e                power_mode,
    // access strobes from the bus fabric toward the gated units
    input  wire logic                converter_access,
    input  wire logic                watchdog_access,
    // AXI4-Lite slave
    input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [DATA_W-1:0]   s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [ADDR_W-1:0]   s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [DATA_W-1:0]        s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    // unit clock enables and fault answers
    output logic                     converter_clk_en,
    output logic                     watchdog_clk_en,
    output logic [1:0]               converter_rate,
    output logic                     converter_fault,
    output logic                     watchdog_fault,
    output logic                     irq
);

    initial begin
        if (MAX_RATE > RATE_500K) begin
            $error("dsg_top: MAX_RATE above the fastest supported code");
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic [31:0] gate_to_word(input dsg_gate_s g, input logic mark);
        logic [31:0] w;
        w = ZERO_WORD;
        w[BIT_CONVERTER_GATE] = g.converter_gate;
        w[BIT_RATE_HI:BIT_RATE_LO] = g.converter_rate_select;
        w[BIT_WATCHDOG_GATE] = g.watchdog_gate;
        w[BIT_RESET_MARK] = mark;
        return w;
    endfunction : gate_to_word

    // only the writable fields are taken; every other bit of the word is dropped
    function automatic dsg_gate_s word_to_gate(input logic [31:0] w);
        dsg_gate_s g;
        g.converter_gate        = w[BIT_CONVERTER_GATE];
        g.converter_rate_select = w[BIT_RATE_HI:BIT_RATE_LO];
        g.watchdog_gate         = w[BIT_WATCHDOG_GATE];
        return g;
    endfunction : word_to_gate

    function automatic logic [31:0] strb_mask(input logic [3:0] strb);
        logic [31:0] m;
        m = ZERO_WORD;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{strb[i]}};
        end
        return m;
    endfunction : strb_mask

    ////////////////////////////////////////////////////////////////////////////////
    // register state

    dsg_gate_s               run_gate_reg0_r;
    dsg_gate_s               sleep_gate_reg0_r;
    dsg_gate_s               deep_sleep_gate_reg0_r;
    logic                    deep_reset_mark_r;
    logic                    auto_clock_gate_select_r;
    logic [NUM_FAULTS-1:0]   fault_status_r;
    logic [NUM_FAULTS-1:0]   fault_enable_r;

    // AXI write side
    logic [ADDR_W-1:0]       aw_addr_r;
    logic                    aw_have_r;
    logic [DATA_W-1:0]       w_data_r;
    logic [3:0]              w_strb_r;
    logic                    w_have_r;
    logic                    do_write;
    logic [31:0]             wmask;
    logic                    wr_hit;
    logic [NUM_FAULTS-1:0]   clear_req;

    assign do_write  = aw_have_r && w_have_r && !s_axi_bvalid;
    assign wmask     = strb_mask(w_strb_r);

    function automatic logic [31:0] merge(input logic [31:0] old);
        return (old & ~wmask) | (w_data_r & wmask);
    endfunction : merge

    ////////////////////////////////////////////////////////////////////////////////
    // write address and data capture, in either order

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_have_r     <= 1'b0;
            aw_addr_r     <= '0;
            s_axi_awready <= 1'b1;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r     <= 1'b1;
            aw_addr_r     <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            aw_have_r     <= 1'b0;
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            w_have_r     <= 1'b0;
            w_data_r     <= '0;
            w_strb_r     <= '0;
            s_axi_wready <= 1'b1;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_have_r     <= 1'b1;
            w_data_r     <= s_axi_wdata;
            w_strb_r     <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            w_have_r     <= 1'b0;
            s_axi_wready <= 1'b1;
        end
    end

    always_comb begin
        case (aw_addr_r)
            OFS_RUN_CLOCK_CONFIG,
            OFS_RUN_GATE_REG0,
            OFS_SLEEP_GATE_REG0,
            OFS_DEEP_GATE_REG0,
            OFS_FAULT_STATUS,
            OFS_FAULT_ENABLE,
            OFS_FAULT_CLEAR:   wr_hit = 1'b1;
            default:           wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // gate registers

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            run_gate_reg0_r <= GATE_RESET;
        end else if (do_write && aw_addr_r == OFS_RUN_GATE_REG0) begin
            run_gate_reg0_r <= word_to_gate(merge(gate_to_word(run_gate_reg0_r, 1'b0)));
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sleep_gate_reg0_r <= GATE_RESET;
        end else if (do_write && aw_addr_r == OFS_SLEEP_GATE_REG0) begin
            sleep_gate_reg0_r <= word_to_gate(merge(gate_to_word(sleep_gate_reg0_r, 1'b0)));
        end
    end

    // the reset mark shows the documented reset word until software first writes
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            deep_sleep_gate_reg0_r <= GATE_RESET;
            deep_reset_mark_r      <= DEEP_GATE_RESET[BIT_RESET_MARK];
        end else if (do_write && aw_addr_r == OFS_DEEP_GATE_REG0) begin
            deep_sleep_gate_reg0_r <=
                word_to_gate(merge(gate_to_word(deep_sleep_gate_reg0_r, 1'b0)));
            deep_reset_mark_r      <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            auto_clock_gate_select_r <= 1'b0;
        end else if (do_write && aw_addr_r == OFS_RUN_CLOCK_CONFIG && w_strb_r[0]) begin
            auto_clock_gate_select_r <= w_data_r[BIT_AUTO_GATE_SEL];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // mode select and unit clock enables

    dsg_gate_s active_gate;
    logic [1:0] rate_limited;

    dsg_gate_sel u_gate_sel (
        .mode                   (power_mode),
        .auto_clock_gate_select (auto_clock_gate_select_r),
        .run_gate               (run_gate_reg0_r),
        .sleep_gate             (sleep_gate_reg0_r),
        .deep_gate              (deep_sleep_gate_reg0_r),
        .active_gate            (active_gate)
    );

    // a faster request than the part allows is held at the ceiling
    assign rate_limited = (active_gate.converter_rate_select > MAX_RATE) ?
                          MAX_RATE : active_gate.converter_rate_select;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            converter_clk_en <= 1'b0;
            watchdog_clk_en  <= 1'b0;
            converter_rate   <= RATE_125K;
        end else begin
            converter_clk_en <= active_gate.converter_gate;
            watchdog_clk_en  <= active_gate.watchdog_gate;
            converter_rate   <= rate_limited;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // bus faults for gated units

    logic [NUM_FAULTS-1:0] fault_evt;

    // judged against the enable that the unit sees right now
    assign fault_evt[BIT_FAULT_CONV] = converter_access && !converter_clk_en;
    assign fault_evt[BIT_FAULT_WDOG] = watchdog_access && !watchdog_clk_en;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            converter_fault <= 1'b0;
            watchdog_fault  <= 1'b0;
        end else begin
            converter_fault <= fault_evt[BIT_FAULT_CONV];
            watchdog_fault  <= fault_evt[BIT_FAULT_WDOG];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // fault status, enable and interrupt

    assign clear_req = (do_write && aw_addr_r == OFS_FAULT_CLEAR && w_strb_r[0]) ?
                       w_data_r[NUM_FAULTS-1:0] : '0;

    // a new fault in the clearing cycle stays set
    genvar gi;
    generate
        for (gi = 0; gi < NUM_FAULTS; gi++) begin : g_status
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    fault_status_r[gi] <= 1'b0;
                end else if (fault_evt[gi]) begin
                    fault_status_r[gi] <= 1'b1;
                end else if (clear_req[gi]) begin
                    fault_status_r[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fault_enable_r <= '0;
        end else if (do_write && aw_addr_r == OFS_FAULT_ENABLE && w_strb_r[0]) begin
            fault_enable_r <= w_data_r[NUM_FAULTS-1:0];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(fault_status_r & fault_enable_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read channel

    logic [31:0] rd_word;
    logic        rd_hit;

    always_comb begin
        rd_word = ZERO_WORD;
        rd_hit  = 1'b1;
        case (s_axi_araddr)
            OFS_RUN_CLOCK_CONFIG: rd_word[BIT_AUTO_GATE_SEL] = auto_clock_gate_select_r;
            OFS_RUN_GATE_REG0:    rd_word = gate_to_word(run_gate_reg0_r, 1'b0);
            OFS_SLEEP_GATE_REG0:  rd_word = gate_to_word(sleep_gate_reg0_r, 1'b0);
            OFS_DEEP_GATE_REG0:   rd_word = gate_to_word(deep_sleep_gate_reg0_r,
                                                         deep_reset_mark_r);
            OFS_FAULT_STATUS:     rd_word[NUM_FAULTS-1:0] = fault_status_r;
            OFS_FAULT_ENABLE:     rd_word[NUM_FAULTS-1:0] = fault_enable_r;
            OFS_FAULT_CLEAR:      rd_word = ZERO_WORD;
            default:              rd_hit  = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= ZERO_WORD;
            s_axi_rresp   <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
        end
    end

endmodule : dsg_top
